// [verilog/ssb_pkg.sv]
package ssb_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [15:0] SEQ_DLY_MIN_MS = 16'h03E8;
    localparam logic [15:0] SEQ_DLY_MAX_MS = 16'h2710;
    localparam logic [15:0] SETTLE_MIN_MS = 16'h0032;
    localparam logic [15:0] FLOOR_MIN_MV = 16'h044C;
    localparam logic [15:0] LIMIT_RST = 16'h0000;
    localparam logic [15:0] MS_CNT_RST = 16'h0000;
    localparam logic [7:0] FRAC_FULL = 8'hFF;
    typedef enum logic [1:0] {
        SSB_OPEN,
        SSB_LINK_UP,
        SSB_CONNECTED,
        SSB_TEARDOWN
    } ssb_state_t;
endpackage

// [verilog/ssb_slew_if.sv]
`timescale 1ns/100ps
interface ssb_slew_if;
    logic [15:0] target;
    logic [15:0] attack_ms;
    logic [15:0] decay_ms;
    logic force_zero;
    logic tick;
    logic [15:0] value;
    modport ctrl (
        output target,
        output attack_ms,
        output decay_ms,
        output force_zero,
        output tick,
        input value
    );
    modport slew (
        input target,
        input attack_ms,
        input decay_ms,
        input force_zero,
        input tick,
        output value
    );
endinterface

// [verilog/ssb_slew.sv]
`timescale 1ns/100ps
module ssb_slew
    import ssb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    ssb_slew_if.slew sl
);
    logic [15:0] value_reg;
    logic [15:0] value_next;
    logic [15:0] diff;
    logic [15:0] settle;
    logic [15:0] step_raw;
    logic [15:0] step;
    logic falling;

    // first-order approach: each ms tick covers diff / settle_time of the gap
    assign falling = sl.target < value_reg;
    assign diff = falling ? value_reg - sl.target : sl.target - value_reg;
    assign settle = falling ? sl.attack_ms : sl.decay_ms;
    assign step_raw = (settle == MS_CNT_RST) ? diff : diff / settle;
    assign step = (step_raw == LIMIT_RST && diff != LIMIT_RST) ? 16'h0001 : step_raw;

    always_comb
    begin
        value_next = value_reg;
        if (sl.force_zero)
            value_next = LIMIT_RST;
        else if (sl.tick)
            value_next = falling ? value_reg - step : value_reg + step;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            value_reg <= LIMIT_RST;
        else
            value_reg <= value_next;
    end

    assign sl.value = value_reg;
endmodule

// [verilog/ssb_ctrl.sv]
`timescale 1ns/100ps
module ssb_ctrl
    import ssb_pkg::*;
#(
    parameter int NUM_CELLS = 12,
    parameter int NUM_TEMPS = 4,
    parameter int TICK_DIV = TICK_CYCLES
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic connect_req,
    input wire logic disconnect_req,
    input wire logic fault,
    input wire logic precharge_en,
    input wire logic [15:0] link_up_delay_ms,
    input wire logic [15:0] teardown_delay_ms,
    output logic contactors_closed,
    output logic limits_engaged,
    output logic [1:0] stack_state,
    input wire logic [15:0] max_charge_current,
    input wire logic [15:0] max_discharge_current,
    input wire logic [15:0] min_charge_current,
    input wire logic [7:0] charge_throttle,
    input wire logic [7:0] discharge_throttle,
    input wire logic at_max_charge_voltage,
    input wire logic nonlinear_rolloff,
    input wire logic [15:0] attack_settle_ms,
    input wire logic [15:0] decay_settle_ms,
    output logic [15:0] charge_limit,
    output logic [15:0] discharge_limit,
    input wire logic balancer_enable,
    input wire logic [15:0] balance_floor_mv,
    input wire logic [15:0] balance_delta_mv,
    input wire logic signed [15:0] max_balance_temp_c,
    input wire logic signed [31:0] min_balance_current_ma,
    input wire logic signed [31:0] max_balance_current_ma,
    input wire logic signed [31:0] stack_current_ma,
    input wire logic [NUM_CELLS*16-1:0] cell_mv,
    input wire logic [NUM_TEMPS*16-1:0] cell_temp_c,
    input wire logic [15:0] cell_poll_interval,
    input wire logic [15:0] balance_settle_ms,
    output logic [NUM_CELLS-1:0] bleed_en,
    output logic measure_start
);
    ssb_state_t state_reg;
    ssb_state_t state_next;
    logic [16:0] div_reg;
    logic tick_reg;
    logic [15:0] seq_cnt_reg;
    logic [15:0] seq_cnt_next;
    logic [15:0] scan_cnt_reg;
    logic [15:0] scan_cnt_next;
    logic contactors_reg;
    logic engaged_reg;
    logic [15:0] chg_lim_reg;
    logic [15:0] dis_lim_reg;
    logic [NUM_CELLS-1:0] bleed_reg;
    logic measure_reg;

    // sequencing delays held within their bounds; link-up delay is zero when precharge_en is low
    wire [15:0] link_up_bounded;
    wire [15:0] link_up_eff;
    wire [15:0] teardown_eff;
    wire seq_done;
    assign link_up_bounded = (link_up_delay_ms < SEQ_DLY_MIN_MS) ? SEQ_DLY_MIN_MS :
                             (link_up_delay_ms > SEQ_DLY_MAX_MS) ? SEQ_DLY_MAX_MS :
                             link_up_delay_ms;
    assign link_up_eff = precharge_en ? link_up_bounded : MS_CNT_RST;
    assign teardown_eff = (teardown_delay_ms < SEQ_DLY_MIN_MS) ? SEQ_DLY_MIN_MS :
                          (teardown_delay_ms > SEQ_DLY_MAX_MS) ? SEQ_DLY_MAX_MS :
                          teardown_delay_ms;
    assign seq_done = (state_reg == SSB_LINK_UP) ? (seq_cnt_reg >= link_up_eff) :
                      (seq_cnt_reg >= teardown_eff);

    // millisecond enable pulse from the single reference clock
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            div_reg <= 17'h00000;
            tick_reg <= 1'b0;
        end
        else if (div_reg == 17'(TICK_DIV - 1))
        begin
            div_reg <= 17'h00000;
            tick_reg <= 1'b1;
        end
        else
        begin
            div_reg <= div_reg + 17'h00001;
            tick_reg <= 1'b0;
        end
    end

    // stack state machine; fault has priority over every request
    always_comb
    begin
        state_next = state_reg;
        seq_cnt_next = seq_cnt_reg;
        case (state_reg)
            SSB_OPEN:
            begin
                seq_cnt_next = MS_CNT_RST;
                if (connect_req && !fault)
                    state_next = SSB_LINK_UP;
            end
            SSB_LINK_UP:
            begin
                if (fault || disconnect_req)
                    state_next = SSB_OPEN;
                else if (seq_done)
                    state_next = SSB_CONNECTED;
                else if (tick_reg)
                    seq_cnt_next = seq_cnt_reg + 16'h0001;
            end
            SSB_CONNECTED:
            begin
                seq_cnt_next = MS_CNT_RST;
                if (fault)
                    state_next = SSB_OPEN;
                else if (disconnect_req)
                    state_next = SSB_TEARDOWN;
            end
            SSB_TEARDOWN:
            begin
                if (fault)
                    state_next = SSB_OPEN;
                else if (seq_done)
                    state_next = SSB_OPEN;
                else if (tick_reg)
                    seq_cnt_next = seq_cnt_reg + 16'h0001;
            end
            default:
            begin
                state_next = SSB_OPEN;
                seq_cnt_next = MS_CNT_RST;
            end
        endcase
    end

    // contactors stay closed through teardown so the converter ramps down first
    wire contactors_next;
    wire engaged_next;
    assign contactors_next = (state_next == SSB_CONNECTED) ||
                             (state_next == SSB_TEARDOWN);
    assign engaged_next = (state_next == SSB_LINK_UP) ||
                          (state_next == SSB_CONNECTED);

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_reg <= SSB_OPEN;
            seq_cnt_reg <= MS_CNT_RST;
            contactors_reg <= 1'b0;
            engaged_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            seq_cnt_reg <= seq_cnt_next;
            contactors_reg <= contactors_next;
            engaged_reg <= engaged_next;
        end
    end

    // throttle shaping; nonlinear curve flattens near full throttle
    function automatic logic [15:0] shape(input logic [15:0] max_val,
                                          input logic [7:0] frac,
                                          input logic nonlin);
        logic [7:0] inv;
        logic [15:0] sq;
        logic [7:0] f;
        logic [23:0] prod;
        inv = FRAC_FULL - frac;
        sq = inv * inv;
        f = nonlin ? (FRAC_FULL - sq[15:8]) : frac;
        if (frac == FRAC_FULL)
            f = FRAC_FULL;
        prod = max_val * f;
        shape = (f == FRAC_FULL) ? max_val : prod[23:8];
    endfunction

    wire [15:0] chg_shaped;
    wire [15:0] chg_target;
    wire [15:0] dis_target;
    wire connected;
    assign connected = (state_reg == SSB_CONNECTED);
    assign chg_shaped = shape(max_charge_current, charge_throttle, nonlinear_rolloff);
    assign chg_target = (!at_max_charge_voltage && chg_shaped < min_charge_current) ?
                        min_charge_current : chg_shaped;
    assign dis_target = shape(max_discharge_current, discharge_throttle,
                              nonlinear_rolloff);

    ssb_slew_if chg_if ();
    ssb_slew_if dis_if ();

    assign chg_if.target = chg_target;
    assign chg_if.attack_ms = attack_settle_ms;
    assign chg_if.decay_ms = decay_settle_ms;
    assign chg_if.force_zero = !connected;
    assign chg_if.tick = tick_reg;
    assign dis_if.target = dis_target;
    assign dis_if.attack_ms = attack_settle_ms;
    assign dis_if.decay_ms = decay_settle_ms;
    assign dis_if.force_zero = !connected;
    assign dis_if.tick = tick_reg;

    ssb_slew u_chg_slew (
        .ref_clk(ref_clk),
        .rst(rst),
        .sl(chg_if.slew)
    );

    ssb_slew u_dis_slew (
        .ref_clk(ref_clk),
        .rst(rst),
        .sl(dis_if.slew)
    );

    // zero the outputs the same cycle the state leaves connected
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            chg_lim_reg <= LIMIT_RST;
            dis_lim_reg <= LIMIT_RST;
        end
        else
        begin
            chg_lim_reg <= (state_next == SSB_CONNECTED) ? chg_if.value : LIMIT_RST;
            dis_lim_reg <= (state_next == SSB_CONNECTED) ? dis_if.value : LIMIT_RST;
        end
    end

    // scan timing; settle gap held within its bounds
    wire [15:0] poll_eff;
    wire [15:0] settle_cap;
    wire [15:0] settle_eff;
    wire in_settle;
    wire scan_wrap;
    // poll period forced above the minimum gap so a settle window always fits
    assign poll_eff = (cell_poll_interval <= SETTLE_MIN_MS) ?
                      SETTLE_MIN_MS + 16'h0001 : cell_poll_interval;
    assign settle_cap = poll_eff - 16'h0001;
    assign settle_eff = (balance_settle_ms < SETTLE_MIN_MS) ? SETTLE_MIN_MS :
                        (balance_settle_ms > settle_cap) ? settle_cap :
                        balance_settle_ms;
    assign in_settle = scan_cnt_reg < settle_eff;
    assign scan_wrap = scan_cnt_reg >= settle_cap;
    assign scan_cnt_next = !tick_reg ? scan_cnt_reg :
                           scan_wrap ? MS_CNT_RST : scan_cnt_reg + 16'h0001;

    // lowest cell voltage and whether any sensor is above max_balance_temp_c across the stack
    logic [15:0] min_cell;
    logic over_temp;
    always_comb
    begin
        min_cell = 16'hFFFF;
        for (int i = 0; i < NUM_CELLS; i++)
            if (cell_mv[i*16 +: 16] < min_cell)
                min_cell = cell_mv[i*16 +: 16];
    end

    always_comb
    begin
        over_temp = 1'b0;
        for (int i = 0; i < NUM_TEMPS; i++)
            if ($signed(cell_temp_c[i*16 +: 16]) > max_balance_temp_c)
                over_temp = 1'b1;
    end

    // signed compare: charge negative, discharge positive
    wire current_ok;
    wire [15:0] floor_eff;
    wire balance_ok;
    assign current_ok = (stack_current_ma >= min_balance_current_ma) &&
                        (stack_current_ma <= max_balance_current_ma);
    assign floor_eff = (balance_floor_mv < FLOOR_MIN_MV) ? FLOOR_MIN_MV :
                       balance_floor_mv;
    // the floor is judged per cell so one low cell does not stop the rest
    assign balance_ok = balancer_enable && !over_temp && current_ok &&
                        !in_settle;

    // per-cell decision; a zero delta passes every cell above the floor
    logic [NUM_CELLS-1:0] bleed_next;
    always_comb
    begin
        for (int i = 0; i < NUM_CELLS; i++)
            bleed_next[i] = balance_ok &&
                            (cell_mv[i*16 +: 16] > floor_eff) &&
                            (cell_mv[i*16 +: 16] - min_cell >= balance_delta_mv);
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            scan_cnt_reg <= MS_CNT_RST;
            bleed_reg <= '0;
            measure_reg <= 1'b0;
        end
        else
        begin
            scan_cnt_reg <= scan_cnt_next;
            bleed_reg <= bleed_next;
            // measurement starts at the last settle ms, bleed already off
            measure_reg <= tick_reg && (scan_cnt_reg == settle_eff - 16'h0001);
        end
    end

    assign contactors_closed = contactors_reg;
    assign limits_engaged = engaged_reg;
    assign stack_state = state_reg;
    assign charge_limit = chg_lim_reg;
    assign discharge_limit = dis_lim_reg;
    assign bleed_en = bleed_reg;
    assign measure_start = measure_reg;
endmodule

// [testbench/ssb_ctrl_props.sv]
`timescale 1ns/100ps
module ssb_ctrl_props
    import ssb_pkg::*;
#(
    parameter int NUM_CELLS = 12,
    parameter int TICK_DIV = TICK_CYCLES
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic connect_req,
    input wire logic disconnect_req,
    input wire logic fault,
    input wire logic precharge_en,
    input wire logic contactors_closed,
    input wire logic limits_engaged,
    input wire logic [1:0] stack_state,
    input wire logic [15:0] charge_limit,
    input wire logic [15:0] discharge_limit,
    input wire logic balancer_enable,
    input wire logic [15:0] balance_floor_mv,
    input wire logic signed [31:0] min_balance_current_ma,
    input wire logic signed [31:0] max_balance_current_ma,
    input wire logic signed [31:0] stack_current_ma,
    input wire logic [NUM_CELLS*16-1:0] cell_mv,
    input wire logic [NUM_CELLS-1:0] bleed_en,
    input wire logic measure_start
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [1:0] prev_reg;
    int cnt_reg;
    // cycles spent in the current state; only read at state changes
    always_ff @(posedge ref_clk)
    begin
        prev_reg <= stack_state;
        cnt_reg <= (stack_state != prev_reg) ? 0 : cnt_reg + 1;
    end
    sequence link_done_s;
        $past(stack_state) == 2'h1 && stack_state == 2'h2 && precharge_en;
    endsequence
    sequence tear_done_s;
        $past(stack_state) == 2'h3 && stack_state == 2'h0 && !$past(fault);
    endsequence
    link_time_a: assert property (link_done_s |-> cnt_reg >= 999 * TICK_DIV
        && cnt_reg <= 10001 * TICK_DIV) else $error("link-up delay out of bounds");
    tear_time_a: assert property (tear_done_s |-> cnt_reg >= 999 * TICK_DIV
        && cnt_reg <= 10001 * TICK_DIV) else $error("teardown delay out of bounds");
    connect_take_a: assert property (stack_state == 2'h0 && connect_req && !fault
        |=> stack_state == 2'h1 && limits_engaged) else $error("connect not taken");
    close_order_a: assert property ($rose(contactors_closed)
        |-> $past(stack_state) == 2'h1 && $past(limits_engaged)) else $error("early close");
    disc_take_a: assert property (stack_state == 2'h2 && disconnect_req && !fault
        |=> stack_state == 2'h3 && contactors_closed && !limits_engaged)
        else $error("disconnect order wrong");
    fault_open_a: assert property (fault |=> stack_state == 2'h0 && !contactors_closed
        && charge_limit == 16'h0000) else $error("fault did not open at once");
    limits_zero_a: assert property (stack_state != 2'h2
        |-> charge_limit == 16'h0000 && discharge_limit == 16'h0000) else $error("limit not zero");
    bleed_gate_a: assert property (bleed_en != '0 |-> $past(balancer_enable)
        && $past(stack_current_ma) >= $past(min_balance_current_ma)
        && $past(stack_current_ma) <= $past(max_balance_current_ma)) else $error("bleed ungated");
    settle_gap_a: assert property (measure_start |-> bleed_en == '0 ##1 !measure_start)
        else $error("bleed during settle gap");
    for (genvar i = 0; i < NUM_CELLS; i++)
    begin : g_cell
        bleed_floor_a: assert property (bleed_en[i] |-> $past(cell_mv[16*i+:16]) > FLOOR_MIN_MV
            && $past(cell_mv[16*i+:16]) > $past(balance_floor_mv)) else $error("bleed below floor");
    end
endmodule
bind ssb_ctrl ssb_ctrl_props #(.NUM_CELLS(NUM_CELLS), .TICK_DIV(TICK_DIV)) u_props (.ref_clk,
    .rst, .connect_req, .disconnect_req, .fault, .precharge_en, .contactors_closed,
    .limits_engaged, .stack_state, .charge_limit, .discharge_limit, .balancer_enable,
    .balance_floor_mv, .min_balance_current_ma, .max_balance_current_ma, .stack_current_ma,
    .cell_mv, .bleed_en, .measure_start);

// [testbench/ssb_pcs_model.sv]
`timescale 1ns/100ps
module ssb_pcs_model
(
    input wire logic ref_clk,
    input wire logic contactors_closed,
    input wire logic [15:0] charge_limit,
    input wire logic [15:0] discharge_limit,
    input wire logic signed [31:0] demand_ma,
    output logic signed [31:0] stack_current_ma
);
    // converter obeys the limits; open contactors carry no current
    always_ff @(posedge ref_clk)
    begin
        if (!contactors_closed)
            stack_current_ma <= 32'sh00000000;
        else if (demand_ma < -$signed({16'h0000, charge_limit}))
            stack_current_ma <= -$signed({16'h0000, charge_limit});
        else if (demand_ma > $signed({16'h0000, discharge_limit}))
            stack_current_ma <= $signed({16'h0000, discharge_limit});
        else
            stack_current_ma <= demand_ma;
    end
endmodule

// [testbench/ssb_ctrl_tb.sv]
`timescale 1ns/100ps
module ssb_ctrl_tb
    import ssb_pkg::*;
();
    localparam int NC = 4;
    localparam int TD = 10;
    logic ref_clk, rst, connect_req, disconnect_req, fault, precharge_en, measure_start;
    logic at_max_charge_voltage, nonlinear_rolloff, balancer_enable, contactors_closed;
    logic limits_engaged;
    logic [1:0] stack_state;
    logic [7:0] charge_throttle, discharge_throttle;
    logic [15:0] link_up_delay_ms, teardown_delay_ms, max_charge_current, max_discharge_current;
    logic [15:0] min_charge_current, attack_settle_ms, decay_settle_ms, charge_limit;
    logic [15:0] discharge_limit, balance_floor_mv, balance_delta_mv, cell_poll_interval;
    logic [15:0] balance_settle_ms;
    logic signed [15:0] max_balance_temp_c;
    logic signed [31:0] min_balance_current_ma, max_balance_current_ma, stack_current_ma, demand_ma;
    logic [NC*16-1:0] cell_mv;
    logic [31:0] cell_temp_c;
    logic [NC-1:0] bleed_en;
    int error_cnt = 0;
    int checks = 0;
    ssb_ctrl #(.NUM_CELLS(NC), .NUM_TEMPS(2), .TICK_DIV(TD)) dut (.ref_clk, .rst, .connect_req,
        .disconnect_req, .fault, .precharge_en, .link_up_delay_ms, .teardown_delay_ms,
        .contactors_closed, .limits_engaged, .stack_state, .max_charge_current,
        .max_discharge_current, .min_charge_current, .charge_throttle, .discharge_throttle,
        .at_max_charge_voltage, .nonlinear_rolloff, .attack_settle_ms, .decay_settle_ms,
        .charge_limit, .discharge_limit, .balancer_enable, .balance_floor_mv, .balance_delta_mv,
        .max_balance_temp_c, .min_balance_current_ma, .max_balance_current_ma, .stack_current_ma,
        .cell_mv, .cell_temp_c, .cell_poll_interval, .balance_settle_ms, .bleed_en, .measure_start);
    ssb_pcs_model pcs (.ref_clk, .contactors_closed, .charge_limit, .discharge_limit,
        .demand_ma, .stack_current_ma);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wait_state(input logic [1:0] s, input int lim);
        int n;
        n = 0;
        while (stack_state !== s && n < lim)
        begin
            tick(1);
            n++;
        end
    endtask
    // unthrottled is exact, not max*255/256
    function automatic logic [15:0] lim_exp(input logic [15:0] mx, input logic [7:0] f,
        input logic nl);
        logic [15:0] fp;
        fp = nl ? 16'h00FF - (((16'h00FF - f) * (16'h00FF - f)) >> 8) : {8'h00, f};
        return (f == 8'hFF) ? mx : 16'((32'(mx) * fp) >> 8);
    endfunction
    function automatic logic [NC-1:0] bal_exp();
        logic [NC-1:0] r;
        logic [15:0] mn;
        logic [15:0] fl;
        logic ok;
        mn = 16'hFFFF;
        fl = (balance_floor_mv < FLOOR_MIN_MV) ? FLOOR_MIN_MV : balance_floor_mv;
        ok = balancer_enable && stack_current_ma >= min_balance_current_ma
            && stack_current_ma <= max_balance_current_ma;
        for (int j = 0; j < 2; j++)
            ok = ok && !($signed(cell_temp_c[16*j+:16]) > max_balance_temp_c);
        for (int j = 0; j < NC; j++)
            mn = (cell_mv[16*j+:16] < mn) ? cell_mv[16*j+:16] : mn;
        for (int j = 0; j < NC; j++)
            r[j] = ok && cell_mv[16*j+:16] > fl && cell_mv[16*j+:16] - mn >= balance_delta_mv;
        return r;
    endfunction
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial
    begin
        #1000000;
        error_cnt++;
        results();
    end
    initial
    begin
        void'($urandom(32'h33FA));
        rst = 1'b1;
        {connect_req, disconnect_req, fault, precharge_en, nonlinear_rolloff} = '0;
        {link_up_delay_ms, teardown_delay_ms, attack_settle_ms, decay_settle_ms} = '0;
        {charge_throttle, discharge_throttle, balance_delta_mv, cell_mv} = '0;
        {at_max_charge_voltage, balancer_enable} = 2'h3;
        max_charge_current = 16'h4000;
        max_discharge_current = 16'h3000;
        min_charge_current = 16'h0100;
        balance_floor_mv = 16'h044C;
        cell_poll_interval = 16'h0064;
        balance_settle_ms = 16'h0032;
        max_balance_temp_c = 16'sh003C;
        min_balance_current_ma = -32'sh000003E8;
        max_balance_current_ma = 32'sh000003E8;
        demand_ma = -32'sh00000200;
        cell_temp_c = {2{16'h0019}};
        repeat (5) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        check(charge_limit, 16'h0000);
        connect_req = 1'b1;
        tick(1);
        connect_req = 1'b0;
        check(limits_engaged, 1'b1);
        check(contactors_closed, 1'b0);
        wait_state(2'h2, 10);
        for (int i = 0; i < 8; i++)
        begin
            charge_throttle = (i == 0) ? 8'hFF : 8'($urandom_range(0, 224));
            discharge_throttle = (i == 0) ? 8'hFF : 8'($urandom_range(0, 224));
            nonlinear_rolloff = i[0];
            tick(5 * TD);
            check(charge_limit, lim_exp(max_charge_current, charge_throttle, i[0]));
            check(discharge_limit, lim_exp(max_discharge_current, discharge_throttle, i[0]));
        end
        at_max_charge_voltage = 1'b0;
        charge_throttle = 8'h00;
        tick(5 * TD);
        check(charge_limit, min_charge_current);
        decay_settle_ms = 16'h0064;
        charge_throttle = 8'hFF;
        tick(3 * TD);
        check(charge_limit < max_charge_current, 1'b1);
        at_max_charge_voltage = 1'b1;
        charge_throttle = 8'h00;
        tick(5 * TD);
        check(charge_limit, lim_exp(max_charge_current, charge_throttle, nonlinear_rolloff));
        fault = 1'b1;
        tick(1);
        fault = 1'b0;
        check(contactors_closed, 1'b0);
        precharge_en = 1'b1;
        connect_req = 1'b1;
        tick(1);
        connect_req = 1'b0;
        tick(900 * TD);
        check(stack_state, 2'h1);
        wait_state(2'h2, 200 * TD);
        check(stack_state, 2'h2);
        disconnect_req = 1'b1;
        tick(1);
        disconnect_req = 1'b0;
        check(limits_engaged, 1'b0);
        tick(900 * TD);
        check(contactors_closed, 1'b1);
        wait_state(2'h0, 200 * TD);
        check(contactors_closed, 1'b0);
        for (int k = 0; k < 7; k++)
        begin
            for (int j = 0; j < NC; j++)
                cell_mv[16*j+:16] = 16'(3000 + $urandom_range(0, 100));
            if (k == 4)
                cell_mv = {NC{16'h0BB8}};
            if (k == 0)
                cell_mv[15:0] = 16'h0400;
            balance_settle_ms = (k == 1) ? 16'h0000 : (k == 2) ? 16'h00C8 : 16'h0032;
            balance_delta_mv = (k == 4) ? 16'h0000 : 16'($urandom_range(0, 40));
            balancer_enable = (k != 1);
            cell_temp_c = (k == 2) ? {16'h003D, 16'h0019} : {2{16'h0019}};
            min_balance_current_ma = (k == 3) ? 32'sh00000001 : -32'sh000003E8;
            max_balance_current_ma = (k == 6) ? -32'sh00000001 : 32'sh000003E8;
            balance_floor_mv = (k == 5) ? cell_mv[15:0] : (k == 0) ? 16'h0100 : 16'h044C;
            tick(1);
            for (int n = 0; n < 3000 && measure_start !== 1'b1; n++)
                tick(1);
            check(measure_start, 1'b1);
            check(bleed_en, {NC{1'b0}});
            tick(2);
            check(bleed_en, bal_exp());
        end
        results();
    end
endmodule
